// ==== core/asc_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none
module asc_sequencer #(
    parameter int VOLT_CONV_CYC   = asc_pkg::VOLT_CONV_CYC,
    parameter int LOCAL_CONV_CYC  = asc_pkg::LOCAL_CONV_CYC,
    parameter int REMOTE_CONV_CYC = asc_pkg::REMOTE_CONV_CYC,
    parameter int PASS_CYC        = asc_pkg::PASS_CYC,
    parameter int PASS_SLOW_CYC   = asc_pkg::PASS_SLOW_CYC
) (
    input  wire logic                     mclk,
    input  wire logic                     reset_n,
    input  wire logic [7:0]               regAddr,
    input  wire logic                     regWrite,
    input  wire logic [7:0]               regWdata,
    input  wire logic                     regRead,
    output logic      [7:0]               regRdata,
    output logic                          regRvalid,
    output asc_pkg::asc_conv_req_type     convReq,
    output logic                          convStart,
    input  wire logic [9:0]               convData,
    input  wire logic                     convOverrange,
    output logic      [7:0]               tachMinHigh
);
    logic [7:0]                    cfgTwo;
    logic [7:0]                    cfgSix;
    logic [7:0]                    attenBypass;
    asc_pkg::asc_seq_state_type    state;
    logic [2:0]                    rrChan;
    logic [2:0]                    curChan;
    logic                          avgOffAct;
    logic [23:0]                   slotCnt;
    logic [23:0]                   slotLen;
    logic [3:0]                    readCnt;
    logic [13:0]                   acc;
    logic [9:0]                    sample;
    logic [9:0]                    result;
    logic [23:0]                   passCnt;
    logic [23:0]                   passLen;
    logic                          singleMode;
    logic [2:0]                    nextChan;
    logic                          nextBypass;
    logic [4:0]                    frozen;
    logic [1:0]                    lowBits [0:7];
    logic                          storeEn;
    logic [7:0]                    ramData;
    logic                          rdPend;
    logic                          rdFromRam;
    logic [7:0]                    rdHold;
    logic                          isValueAddr;
    logic [7:0]                    tachMinHighReg;

    assign singleMode  = cfgTwo[asc_pkg::CFG2_SINGLE_BIT];
    assign tachMinHigh = tachMinHighReg;
    assign isValueAddr = (regAddr >= asc_pkg::ADDR_VALUE_BASE) && (regAddr <= asc_pkg::ADDR_VALUE_LAST);

    // configuration registers
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            cfgTwo <= asc_pkg::RST_CFG_TWO;
        end else if (regWrite && regAddr == asc_pkg::ADDR_CFG_TWO) begin
            cfgTwo <= regWdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            cfgSix <= asc_pkg::RST_CFG_SIX;
        end else if (regWrite && regAddr == asc_pkg::ADDR_CFG_SIX) begin
            cfgSix <= regWdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            attenBypass <= asc_pkg::RST_ATTEN_BYPASS;
        end else if (regWrite && regAddr == asc_pkg::ADDR_ATTEN_BYPASS) begin
            attenBypass <= regWdata;
        end
    end

    // one byte serves both the fan tach limit and the channel select
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            tachMinHighReg <= asc_pkg::RST_FAN1_TACH_MIN_HIGH;
        end else if (regWrite && regAddr == asc_pkg::ADDR_FAN1_TACH_MIN_HIGH) begin
            tachMinHighReg <= regWdata;
        end
    end

    // channel and attenuator choice for the conversion about to start
    always_comb begin
        if (singleMode) begin
            nextChan = tachMinHighReg[asc_pkg::CHAN_SEL_LSB +: 3];
        end else begin
            nextChan = rrChan;
        end
        case (nextChan)
            asc_pkg::CH_2V5:       nextBypass = attenBypass[asc_pkg::BYPASS_2V5_BIT];
            asc_pkg::CH_CORE_RAIL: nextBypass = attenBypass[asc_pkg::BYPASS_CORE_BIT];
            asc_pkg::CH_5V:        nextBypass = attenBypass[asc_pkg::BYPASS_5V_BIT];
            asc_pkg::CH_12V:       nextBypass = attenBypass[asc_pkg::BYPASS_12V_BIT];
            default:               nextBypass = 1'b0;
        endcase
        if (nextChan <= asc_pkg::CH_12V && cfgTwo[asc_pkg::CFG2_BYPASS_ALL_BIT]) begin
            nextBypass = 1'b1;
        end
    end

    // slot length follows the latched channel, so a config write cannot stretch a slot
    always_comb begin
        case (curChan)
            asc_pkg::CH_REMOTE1: slotLen = 24'(REMOTE_CONV_CYC);
            asc_pkg::CH_REMOTE2: slotLen = 24'(REMOTE_CONV_CYC);
            asc_pkg::CH_LOCAL:   slotLen = 24'(LOCAL_CONV_CYC);
            default:             slotLen = 24'(VOLT_CONV_CYC);
        endcase
    end

    assign sample  = convOverrange ? asc_pkg::FULL_SCALE : convData;
    assign result  = avgOffAct ? acc[9:0] : acc[13:4];
    assign storeEn = (state == asc_pkg::ST_STORE) && !(curChan <= asc_pkg::CH_12V && frozen[curChan]);
    assign passLen = cfgSix[asc_pkg::CFG6_SLOW_PASS_BIT] ? 24'(PASS_SLOW_CYC) : 24'(PASS_CYC);

    // conversion sequencer
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state     <= asc_pkg::ST_START;
            rrChan    <= asc_pkg::CH_2V5;
            curChan   <= asc_pkg::CH_2V5;
            avgOffAct <= 1'b0;
            slotCnt   <= 24'h000000;
            readCnt   <= 4'h0;
            acc       <= 14'h0000;
            convReq   <= '0;
            convStart <= 1'b0;
        end else begin
            case (state)
                asc_pkg::ST_START: begin
                    curChan   <= nextChan;
                    avgOffAct <= cfgTwo[asc_pkg::CFG2_AVG_OFF_BIT];
                    convReq   <= '{channel: nextChan, bypass: nextBypass};
                    convStart <= 1'b1;
                    slotCnt   <= 24'h000000;
                    readCnt   <= 4'h0;
                    acc       <= 14'h0000;
                    state     <= asc_pkg::ST_CONV;
                end
                asc_pkg::ST_CONV: begin
                    convStart <= 1'b0;
                    if (slotCnt == slotLen - 24'h000001) begin
                        slotCnt <= 24'h000000;
                        acc     <= acc + {4'h0, sample};
                        if (avgOffAct || readCnt == asc_pkg::LAST_READING) begin
                            state <= asc_pkg::ST_STORE;
                        end else begin
                            readCnt   <= readCnt + 4'h1;
                            convStart <= 1'b1;
                        end
                    end else begin
                        slotCnt <= slotCnt + 24'h000001;
                    end
                end
                asc_pkg::ST_STORE: begin
                    if (singleMode) begin
                        state <= asc_pkg::ST_START;
                    end else if (rrChan == asc_pkg::CH_REMOTE2) begin
                        rrChan <= asc_pkg::CH_2V5;
                        state  <= avgOffAct ? asc_pkg::ST_START : asc_pkg::ST_WAIT;
                    end else begin
                        rrChan <= rrChan + 3'h1;
                        state  <= asc_pkg::ST_START;
                    end
                end
                asc_pkg::ST_WAIT: begin
                    if (passCnt >= passLen - 24'h000001) begin
                        state <= asc_pkg::ST_START;
                    end
                end
                default: begin
                    state <= asc_pkg::ST_START;
                end
            endcase
        end
    end

    // pass timer restarts as each round robin pass begins at the first channel, averaged or not
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            passCnt <= 24'h000000;
        end else if (state == asc_pkg::ST_START && !singleMode && rrChan == asc_pkg::CH_2V5) begin
            passCnt <= 24'h000000;
        end else if (passCnt != 24'hffffff) begin
            passCnt <= passCnt + 24'h000001;
        end
    end

    // low two bits of each result, kept beside the ram for the extended reads
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            for (int i = 0; i < 8; i++) begin
                lowBits[i] <= 2'b00;
            end
        end else if (storeEn) begin
            lowBits[curChan] <= result[1:0];
        end
    end

    // freeze flags; ext and value reads hit different addresses so never collide
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            frozen <= 5'h00;
        end else if (regRead) begin
            if (regAddr == asc_pkg::ADDR_EXT_RES_ONE) begin
                frozen[3:0] <= 4'hf;
            end else if (regAddr == asc_pkg::ADDR_EXT_RES_TWO) begin
                frozen[4] <= 1'b1;
            end else if (isValueAddr && regAddr[2:0] <= asc_pkg::CH_12V) begin
                frozen[regAddr[2:0]] <= 1'b0;
            end
        end
    end

    asc_value_ram u_value_ram (
        .mclk    (mclk),
        .reset_n (reset_n),
        .wrEn    (storeEn),
        .wrAddr  (curChan),
        .wrData  (result[9:2]),
        .rdAddr  (regAddr[2:0]),
        .rdData  (ramData)
    );

    // read path: first stage captures, second stage presents
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            rdPend    <= 1'b0;
            rdFromRam <= 1'b0;
            rdHold    <= asc_pkg::RST_READ_DATA;
        end else begin
            rdPend    <= regRead;
            rdFromRam <= isValueAddr;
            case (regAddr)
                asc_pkg::ADDR_CFG_TWO:        rdHold <= cfgTwo;
                asc_pkg::ADDR_CFG_SIX:        rdHold <= cfgSix;
                asc_pkg::ADDR_ATTEN_BYPASS:   rdHold <= attenBypass;
                asc_pkg::ADDR_FAN1_TACH_MIN_HIGH: rdHold <= tachMinHighReg;
                asc_pkg::ADDR_EXT_RES_ONE:    rdHold <= {lowBits[3], lowBits[2], lowBits[1], lowBits[0]};
                asc_pkg::ADDR_EXT_RES_TWO:    rdHold <= {lowBits[7], lowBits[6], lowBits[5], lowBits[4]};
                default:                      rdHold <= asc_pkg::RST_READ_DATA;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            regRdata  <= asc_pkg::RST_READ_DATA;
            regRvalid <= 1'b0;
        end else begin
            regRvalid <= rdPend;
            if (rdPend) begin
                regRdata <= rdFromRam ? ramData : rdHold;
            end
        end
    end
endmodule // asc_sequencer
`default_nettype wire

// ==== core/asc_pkg.sv ====
package asc_pkg;

    // register offsets
    localparam logic [7:0] ADDR_CFG_SIX        = 8'h10;
    localparam logic [7:0] ADDR_VALUE_BASE     = 8'h20;
    localparam logic [7:0] ADDR_VALUE_LAST     = 8'h27;
    localparam logic [7:0] ADDR_FAN1_TACH_MIN_HIGH = 8'h55;
    localparam logic [7:0] ADDR_CFG_TWO        = 8'h73;
    localparam logic [7:0] ADDR_EXT_RES_ONE    = 8'h76;
    localparam logic [7:0] ADDR_EXT_RES_TWO    = 8'h77;
    localparam logic [7:0] ADDR_ATTEN_BYPASS   = 8'h7d;

    // reset values
    localparam logic [7:0] RST_CFG_SIX         = 8'h00;
    localparam logic [7:0] RST_CFG_TWO         = 8'h00;
    localparam logic [7:0] RST_FAN1_TACH_MIN_HIGH  = 8'hff;
    localparam logic [7:0] RST_ATTEN_BYPASS    = 8'h00;
    localparam logic [7:0] RST_READ_DATA       = 8'h00;

    // field positions
    localparam int CFG2_AVG_OFF_BIT    = 4;
    localparam int CFG2_BYPASS_ALL_BIT = 5;
    localparam int CFG2_SINGLE_BIT     = 6;
    localparam int CFG6_SLOW_PASS_BIT  = 7;
    localparam int CHAN_SEL_LSB        = 5;
    localparam int BYPASS_2V5_BIT      = 4;
    localparam int BYPASS_CORE_BIT     = 5;
    localparam int BYPASS_5V_BIT       = 6;
    localparam int BYPASS_12V_BIT      = 7;

    // channel codes, round robin order
    localparam logic [2:0] CH_2V5       = 3'h0;
    localparam logic [2:0] CH_CORE_RAIL = 3'h1;
    localparam logic [2:0] CH_SUPPLY    = 3'h2;
    localparam logic [2:0] CH_5V        = 3'h3;
    localparam logic [2:0] CH_12V       = 3'h4;
    localparam logic [2:0] CH_REMOTE1   = 3'h5;
    localparam logic [2:0] CH_LOCAL     = 3'h6;
    localparam logic [2:0] CH_REMOTE2   = 3'h7;

    // converter figures
    localparam logic [3:0] LAST_READING = 4'hf;
    localparam logic [9:0] FULL_SCALE   = 10'h3ff;

    // timing in microseconds, or in hundreds of microseconds for the _US10 figures, and the clock rate in MHz
    localparam int CLK_MHZ         = 40;
    localparam int VOLT_CONV_US10  = 7;
    localparam int LOCAL_CONV_US10 = 13;
    localparam int REMOTE_CONV_US  = 7000;
    localparam int PASS_US10       = 1465;
    localparam int PASS_SLOW_US    = 240000;

    // times in cycles; every figure divides evenly at this rate
    localparam int VOLT_CONV_CYC   = VOLT_CONV_US10 * 100 * CLK_MHZ;
    localparam int LOCAL_CONV_CYC  = LOCAL_CONV_US10 * 100 * CLK_MHZ;
    localparam int REMOTE_CONV_CYC = REMOTE_CONV_US * CLK_MHZ;
    localparam int PASS_CYC        = PASS_US10 * 100 * CLK_MHZ;
    localparam int PASS_SLOW_CYC   = PASS_SLOW_US * CLK_MHZ;

    typedef struct packed {
        logic [2:0] channel;
        logic       bypass;
    } asc_conv_req_type;

    typedef enum logic [1:0] {
        ST_START = 2'b00,
        ST_CONV  = 2'b01,
        ST_STORE = 2'b10,
        ST_WAIT  = 2'b11
    } asc_seq_state_type;

endpackage

// ==== core/asc_value_ram.sv ====
`timescale 1ns/1ps
`default_nettype none
module asc_value_ram (
    input  wire logic       mclk,
    input  wire logic       reset_n,
    input  wire logic       wrEn,
    input  wire logic [2:0] wrAddr,
    input  wire logic [7:0] wrData,
    input  wire logic [2:0] rdAddr,
    output logic      [7:0] rdData
);
    logic [7:0] mem [0:7];

    // contents cleared so every value register reads zero before its first result
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            for (int i = 0; i < 8; i++) begin
                mem[i] <= 8'h00;
            end
        end else if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            rdData <= 8'h00;
        end else begin
            rdData <= mem[rdAddr];
        end
    end
endmodule // asc_value_ram
`default_nettype wire

// ==== sim/asc_conv_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module asc_conv_model (
    input  wire logic                      mclk,
    input  wire logic                      reset_n,
    input  wire asc_pkg::asc_conv_req_type convReq,
    input  wire logic                      convStart,
    output logic [9:0]                     convData,
    output logic                           convOverrange
);
    asc_pkg::asc_conv_req_type held = '0;
    logic [3:0]                reading = 4'h0;

    // input ramps one step per reading so an averaged code differs from a single one;
    // updated mid-cycle so it is settled before the converter samples
    always @(negedge mclk) begin
        if (!reset_n) begin
            held    <= '0;
            reading <= 4'h0;
        end else if (convStart) begin
            held    <= convReq;
            reading <= (convReq != held) ? 4'h0 : reading + 4'h1;
        end
    end

    assign convData      = {held.channel, held.bypass, 2'b00, reading};
    assign convOverrange = held.channel == asc_pkg::CH_12V;
endmodule // asc_conv_model
`default_nettype wire

// ==== sim/asc_sequencer_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module asc_sequencer_chk #(
    parameter int VOLT_CONV_CYC   = 2,
    parameter int LOCAL_CONV_CYC  = 3,
    parameter int REMOTE_CONV_CYC = 4,
    parameter int PASS_CYC        = 400,
    parameter int PASS_SLOW_CYC   = 700
) (
    input wire logic                      mclk,
    input wire logic                      reset_n,
    input wire logic [7:0]                regAddr,
    input wire logic                      regWrite,
    input wire logic [7:0]                regWdata,
    input wire logic                      regRead,
    input wire logic [7:0]                regRdata,
    input wire logic                      regRvalid,
    input wire asc_pkg::asc_conv_req_type convReq,
    input wire logic                      convStart,
    input wire logic [9:0]                convData,
    input wire logic                      convOverrange,
    input wire logic [7:0]                tachMinHigh
);
    logic [7:0]                cfgTwo;
    logic [7:0]                selReg;
    logic                      sglEver;
    logic                      avgOffMeas;
    logic                      passClean;
    logic                      passSlow;
    logic                      slowCfg;
    logic [4:0]                rdCnt;
    logic [15:0]               gapCnt;
    logic [15:0]               passCnt;
    asc_pkg::asc_conv_req_type prevReq;
    logic                      chg;
    int                        passLen;
    int                        slotLen;

    // a new measurement shows as a changed request; round robin never repeats one
    assign chg     = convReq != prevReq;
    assign passLen = passSlow ? PASS_SLOW_CYC : PASS_CYC;
    assign slotLen = (convReq.channel < 3'h5) ? VOLT_CONV_CYC
                   : (convReq.channel == 3'h6) ? LOCAL_CONV_CYC : REMOTE_CONV_CYC;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            cfgTwo  <= 8'h00;
            slowCfg <= 1'b0;
            selReg  <= 8'hff;
            sglEver <= 1'b0;
        end else if (regWrite) begin
            if (regAddr == asc_pkg::ADDR_CFG_TWO) cfgTwo <= regWdata;
            if (regAddr == asc_pkg::ADDR_CFG_SIX) slowCfg <= regWdata[7];
            if (regAddr == asc_pkg::ADDR_FAN1_TACH_MIN_HIGH) selReg <= regWdata;
            if (regAddr == asc_pkg::ADDR_CFG_TWO && regWdata[6]) sglEver <= 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            prevReq    <= '0;
            rdCnt      <= 5'h0;
            gapCnt     <= 16'h0;
            passCnt    <= 16'h0;
            avgOffMeas <= 1'b0;
            passClean  <= 1'b0;
            passSlow   <= 1'b0;
        end else begin
            prevReq <= convReq;
            gapCnt  <= convStart ? 16'h1 : gapCnt + 16'h1;
            passCnt <= passCnt + 16'h1;
            if (convStart) rdCnt <= chg ? 5'h1 : rdCnt + 5'h1;
            if (chg) avgOffMeas <= cfgTwo[4];
            if (chg && convReq.channel == 3'h0) begin
                passCnt   <= 16'h1;
                passClean <= !cfgTwo[4];
                passSlow  <= slowCfg;
            end
            // a pass whose settings moved midway has no defined length
            if (regWrite && (regAddr == asc_pkg::ADDR_CFG_TWO || regAddr == asc_pkg::ADDR_CFG_SIX)) passClean <= 1'b0;
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    sequence s_answer;
        ##2 regRvalid;
    endsequence

    AST_READ_LAT:
    assert property (regRead |-> s_answer) else $error("read answer late");
    AST_RVALID_CAUSE:
    assert property (regRvalid |-> $past(regRead, 2)) else $error("answer without read");
    AST_TACH_SHARE:
    assert property (regWrite && regAddr == asc_pkg::ADDR_FAN1_TACH_MIN_HIGH |=> tachMinHigh == $past(regWdata))
        else $error("tach byte not updated");
    AST_ORDER:
    assert property (chg && !sglEver |-> convReq.channel == prevReq.channel + 3'h1)
        else $error("channel order wrong");
    AST_AVERAGE:
    assert property (chg && !sglEver |-> rdCnt == (avgOffMeas ? 5'h1 : 5'h10))
        else $error("reading count wrong");
    AST_SLOT:
    assert property (convStart && !chg && rdCnt != 5'h0 && !sglEver |-> gapCnt == slotLen)
        else $error("reading slot length wrong");
    AST_SINGLE:
    assert property (chg && cfgTwo[6] |-> convReq.channel == selReg[7:5])
        else $error("single channel wrong");
    AST_PASS:
    assert property (chg && convReq.channel == 3'h0 && passClean && !sglEver |-> passCnt + 1 >= passLen
        && passCnt <= passLen + 2) else $error("pass time wrong");
endmodule // asc_sequencer_chk

bind asc_sequencer asc_sequencer_chk #(
    .VOLT_CONV_CYC(VOLT_CONV_CYC), .LOCAL_CONV_CYC(LOCAL_CONV_CYC), .REMOTE_CONV_CYC(REMOTE_CONV_CYC),
    .PASS_CYC(PASS_CYC), .PASS_SLOW_CYC(PASS_SLOW_CYC)
) u_chk (
    .mclk(mclk), .reset_n(reset_n), .regAddr(regAddr), .regWrite(regWrite), .regWdata(regWdata),
    .regRead(regRead), .regRdata(regRdata), .regRvalid(regRvalid), .convReq(convReq),
    .convStart(convStart), .convData(convData), .convOverrange(convOverrange), .tachMinHigh(tachMinHigh)
);
`default_nettype wire

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int PASS = 400;
    localparam int SLOW = 700;
    logic                      mclk = 1'b0;
    logic                      reset_n = 1'b0;
    logic [7:0]                regAddr = 8'h00;
    logic                      regWrite = 1'b0;
    logic [7:0]                regWdata = 8'h00;
    logic                      regRead = 1'b0;
    logic [7:0]                regRdata;
    logic                      regRvalid;
    asc_pkg::asc_conv_req_type convReq;
    logic                      convStart;
    logic [9:0]                convData;
    logic                      convOverrange;
    logic [7:0]                tachMinHigh;
    logic [7:0]                bypCfg;
    logic [7:0]                expQ[$];
    int                        err_total = 0;
    int                        checks = 0;

    always #12.5 mclk = ~mclk;

    asc_sequencer #(.VOLT_CONV_CYC(2), .LOCAL_CONV_CYC(3), .REMOTE_CONV_CYC(4), .PASS_CYC(PASS),
        .PASS_SLOW_CYC(SLOW)) DUT (
        .mclk(mclk), .reset_n(reset_n), .regAddr(regAddr), .regWrite(regWrite), .regWdata(regWdata),
        .regRead(regRead), .regRdata(regRdata), .regRvalid(regRvalid), .convReq(convReq),
        .convStart(convStart), .convData(convData), .convOverrange(convOverrange), .tachMinHigh(tachMinHigh)
    );

    asc_conv_model partner (
        .mclk(mclk), .reset_n(reset_n), .convReq(convReq), .convStart(convStart),
        .convData(convData), .convOverrange(convOverrange)
    );

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h got %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        regAddr  = a;
        regWdata = d;
        regWrite = 1'b1;
        @(negedge mclk);
        regWrite = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge mclk);
        regAddr = a;
        regRead = 1'b1;
        expQ.push_back(e);
        @(negedge mclk);
        regRead = 1'b0;
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge mclk);
    endtask

    // stored code: full scale for the 12V channel, otherwise channel, bypass, then whether sixteen ramped readings were averaged
    function automatic logic [7:0] valExp(input int ch, input logic [7:0] two, input logic avg);
        logic b;
        b = ch < 5 && (two[5] || (ch == 0 && bypCfg[4]) || (ch == 1 && bypCfg[5]) || (ch == 3 && bypCfg[6]));
        return (ch == 4) ? 8'hff : {ch[2:0], b, 3'h0, avg};
    endfunction

    always @(negedge mclk) begin
        if (regRvalid === 1'b1) begin
            if (expQ.size() == 0) begin
                err_total++;
                $display("[FAIL] regRvalid expected 0 got 1");
            end else begin
                check("regRdata", expQ.pop_front(), regRdata);
            end
        end
    end

    task automatic conclude;
        if (err_total == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        err_total++;
        conclude();
    end

    initial begin
        logic [7:0] v;
        void'($urandom(78));
        idle(6);
        reset_n = 1'b1;
        rd(asc_pkg::ADDR_FAN1_TACH_MIN_HIGH, 8'hff);
        rd(asc_pkg::ADDR_CFG_TWO, 8'h00);
        rd(asc_pkg::ADDR_ATTEN_BYPASS, 8'h00);
        rd(asc_pkg::ADDR_CFG_SIX, 8'h00);
        wr(8'h30, 8'h5a);
        rd(8'h30, 8'h00);
        v = 8'($urandom);
        wr(asc_pkg::ADDR_FAN1_TACH_MIN_HIGH, v);
        check("tachMinHigh", v, tachMinHigh);
        rd(asc_pkg::ADDR_FAN1_TACH_MIN_HIGH, v);
        bypCfg = 8'($urandom);
        wr(asc_pkg::ADDR_ATTEN_BYPASS, bypCfg);
        rd(asc_pkg::ADDR_ATTEN_BYPASS, bypCfg);
        idle(2 * PASS + 50);
        rd(asc_pkg::ADDR_EXT_RES_ONE, 8'hff);
        rd(asc_pkg::ADDR_EXT_RES_TWO, 8'hff);
        for (int ch = 0; ch < 8; ch++) rd(8'h20 + 8'(ch), valExp(ch, 8'h00, 1'b1));
        rd(asc_pkg::ADDR_EXT_RES_ONE, 8'hff);
        rd(asc_pkg::ADDR_EXT_RES_TWO, 8'hff);
        wr(asc_pkg::ADDR_CFG_TWO, 8'h30);
        idle(200);
        for (int ch = 0; ch < 8; ch++) rd(8'h20 + 8'(ch), valExp(ch, ch < 5 ? 8'h00 : 8'h30, ch < 5));
        idle(100);
        for (int ch = 0; ch < 8; ch++) rd(8'h20 + 8'(ch), valExp(ch, 8'h30, 1'b0));
        rd(asc_pkg::ADDR_EXT_RES_TWO, 8'h03);
        wr(asc_pkg::ADDR_CFG_TWO, 8'h00);
        wr(asc_pkg::ADDR_CFG_SIX, 8'h80);
        rd(asc_pkg::ADDR_CFG_SIX, 8'h80);
        idle(3 * SLOW);
        wr(asc_pkg::ADDR_FAN1_TACH_MIN_HIGH, 8'h00);
        wr(asc_pkg::ADDR_CFG_TWO, 8'h60);
        for (int c = 0; c < 8; c++) begin
            wr(asc_pkg::ADDR_FAN1_TACH_MIN_HIGH, {c[2:0], 5'h0a});
            idle(SLOW + 100);
            rd(8'h20 + 8'(c), valExp(c, 8'h60, 1'b1));
            if (c < 7) rd(8'h21 + 8'(c), valExp(c + 1, 8'h00, 1'b1));
        end
        idle(10);
        conclude();
    end
endmodule // testbench
`default_nettype wire
